/* File: hw/gyspi_cfg.svh */
// constants of the sensor serial slave port: field positions, mode threshold, timing counts
// assumes a 40 MHz system clock; included by the package and the port module
// What this block does
// RL1: each input bit is captured on a rising serial clock edge while chip select is low.
// RL2: after each falling serial clock edge the output moves to the next bit, the first bit excepted.
// RL3: the first output bit stands on the output line as soon as chip select falls.
// RL4: the output line floats whenever chip select is high.
// RL5: chip select is active low, held low by the master for a transfer, and traffic counts only then.
// RL6: a sample period setting up to 0x07 means normal mode, 0x08 and above low-power mode.
// RL7: the master keeps the serial clock within 0.01 to 2.5 MHz, or at most 1.0 MHz in low-power mode; the host model clocks at 8 MHz in both modes.
// RL8: the master pauses 9 us (12 us low-power) between words, with a 32 us start-to-start period; the port checks a 42 us period in low-power mode.
// RL9: a read is a command word followed by a second word that carries the data back.
// RL10: a 7-bit address naming either byte of a 16-bit register selects that register.
// RL11: a write word carries one data byte, so a full register takes two write words.
// RL12: a write command acts right after the sixteenth rising edge of its word.
// RL13: the bit counters restart at each chip select fall and the clock is ignored while deselected.
`ifndef GYSPI_CFG_SVH
`define GYSPI_CFG_SVH

`define GYSPI_CLK_KHZ        40000
`define GYSPI_NS2CYC(ns)     (((ns) * `GYSPI_CLK_KHZ + 999999) / 1000000)
`define GYSPI_WORD_BITS      16
`define GYSPI_FIFO_DEPTH     32
`define GYSPI_RW_BIT         15
`define GYSPI_ADDR_MSB       14
`define GYSPI_ADDR_LSB       8
`define GYSPI_REG_LSB        9
`define GYSPI_DATA_MSB       7
`define GYSPI_LP_MIN         8'h08
`define GYSPI_STALL_NORM_NS  9000
`define GYSPI_STALL_LP_NS    12000
`define GYSPI_PERIOD_NORM_NS 32000
`define GYSPI_PERIOD_LP_NS   42000
`define GYSPI_CNT_W          11
`define GYSPI_TX_RESET       16'h0000

`endif

/* File: hw/gyspi_pkg.sv */
// types shared by the serial slave port and its user side
// assumes gyspi_cfg.svh is on the include path
`include "gyspi_cfg.svh"

package gyspi_pkg;

    // one decoded command word as handed to the register side
    typedef struct packed {
        logic       write;      // 1 = write of one byte
        logic [5:0] reg_index;  // 16-bit register selected
        logic       byte_sel;   // address lsb: which byte was named
        logic [7:0] data;       // write byte
    } gyspi_cmd_type;

    // word hand-off towards the fifo
    typedef enum logic [0:0] {
        GYSPI_ST_IDLE = 1'b0,
        GYSPI_ST_HOLD = 1'b1
    } gyspi_state_type;

endpackage : gyspi_pkg

/* File: hw/gyspi_fifo.sv */
// first-in first-out buffer with a registered output stage
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module gyspi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,        // system clock
    input  wire logic             srst_in,       // sync reset
    input  wire logic             in_valid_in,   // write request
    output logic                  in_ready_out,  // room left
    input  wire logic [WIDTH-1:0] in_data_in,    // write data
    output logic                  out_valid_out, // output word present
    input  wire logic             out_ready_in,  // output taken
    output logic      [WIDTH-1:0] out_data_out   // output word
);
    localparam int AW = $clog2(DEPTH);

    // pointers wrap naturally, so only powers of two are served
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_param
        $error("gyspi_fifo: depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             load;

    // full is judged on the stored words only; the output stage is extra
    assign in_ready_out = (count != (AW + 1)'(DEPTH));
    assign push = in_valid_in && in_ready_out;
    assign load = (count != '0) && (!out_valid_out || out_ready_in);

    // storage array, no reset needed
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem[wr_ptr] <= in_data_in;
    end

    // pointers and fill level
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(load);
            count  <= count + (AW + 1)'(push) - (AW + 1)'(load);
        end
    end

    // registered read port
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
        end
        else if (load)
        begin
            out_valid_out <= 1'b1;
            out_data_out  <= mem[rd_ptr];
        end
        else if (out_ready_in)
            out_valid_out <= 1'b0;
    end

endmodule : gyspi_fifo
`default_nettype wire

/* File: hw/gyspi_port.sv */
// serial slave port of the sensor: mode 3 shifting, word hand-off, read reply, mode and pacing checks
// assumes sclk_in is the master's clock, idle high, stopped outside frames; clk_in runs at 40 MHz
`include "gyspi_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module gyspi_port #(
    parameter int FIFO_DEPTH = `GYSPI_FIFO_DEPTH
) (
    input  wire logic                  clk_in,                    // system clock
    input  wire logic                  srst_in,                   // sync reset
    input  wire logic                  sclk_in,                   // serial clock
    input  wire logic                  cs_n_in,                   // chip select, low active
    input  wire logic                  din_in,                    // serial data in
    output logic                       dout_out,                  // serial data out
    output logic                       dout_oe_n_out,             // output enable, low drives
    input  wire logic [7:0]            sample_period_setting_in,  // sample period setting
    output logic                       low_power_out,             // low-power mode flag
    output logic                       cmd_valid_out,             // command word waiting
    input  wire logic                  cmd_ready_in,              // command taken
    output gyspi_pkg::gyspi_cmd_type   cmd_out,                   // decoded command
    input  wire logic                  resp_valid_in,             // reply word offered
    input  wire logic [15:0]           resp_data_in,              // reply word
    output logic                       resp_ready_out,            // reply can be loaded
    output logic                       overrun_out,               // word lost pulse
    output logic                       timing_error_out           // pacing violation pulse
);
    import gyspi_pkg::*;

    localparam int CW = `GYSPI_CNT_W;
    localparam logic [CW-1:0] STALL_NORM  = CW'(`GYSPI_NS2CYC(`GYSPI_STALL_NORM_NS));
    localparam logic [CW-1:0] STALL_LP    = CW'(`GYSPI_NS2CYC(`GYSPI_STALL_LP_NS));
    localparam logic [CW-1:0] PERIOD_NORM = CW'(`GYSPI_NS2CYC(`GYSPI_PERIOD_NORM_NS));
    localparam logic [CW-1:0] PERIOD_LP   = CW'(`GYSPI_NS2CYC(`GYSPI_PERIOD_LP_NS));

    if (FIFO_DEPTH < 2)
    begin : g_bad_depth
        $error("gyspi_port: fifo depth too small");
    end

    // serial clock domain
    logic [3:0]  rx_cnt;
    logic [14:0] rx_shift;
    logic [15:0] rx_word;
    logic        rx_toggle;
    logic [3:0]  tx_cnt;
    logic [3:0]  next_tx_cnt;
    logic [3:0]  next_tx_idx;
    logic [3:0]  cur_tx_idx;
    logic        tx_bit;
    logic        first_pending;

    // system clock domain
    logic [1:0]      sync1;
    logic [1:0]      sync2;
    logic [1:0]      sync3;
    logic [1:0]      filt;
    logic [1:0]      next_filt;
    logic            cs_idle;
    logic            cs_idle_q;
    logic            seen_toggle;
    logic            word_evt;
    logic            cs_fall;
    logic            cs_rise;
    logic [15:0]     tx_word;
    gyspi_state_type push_state;
    gyspi_cmd_type   push_cmd;
    logic            fifo_in_ready;
    logic            seen_word;
    logic [CW-1:0]   period_cnt;
    logic [CW-1:0]   stall_cnt;
    logic [CW-1:0]   period_min;
    logic [CW-1:0]   stall_min;
    logic            lp_mode;

    // receive shifter; chip select high clears it and blocks the clock
    always_ff @(posedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
        begin
            rx_cnt   <= 4'h0;                                   // RL13
            rx_shift <= 15'h0000;
        end
        else
        begin
            rx_cnt   <= rx_cnt + 4'h1;
            rx_shift <= {rx_shift[13:0], din_in};               // RL1
        end
    end

    // word capture on the sixteenth rising edge; held until the next word ends
    always_ff @(posedge sclk_in)
    begin
        if (!cs_n_in && rx_cnt == 4'hF)
            rx_word <= {rx_shift, din_in};                      // RL5
    end

    // event toggle for the system side; the serial clock cannot be relied on
    // to clear it, so the system reset clears it asynchronously
    always_ff @(posedge sclk_in or posedge srst_in)
    begin
        if (srst_in)
            rx_toggle <= 1'b0;
        else if (!cs_n_in && rx_cnt == 4'hF)
            rx_toggle <= ~rx_toggle;                            // RL12
    end

    // first falling edge keeps the msb, each later one steps one bit down
    assign next_tx_cnt = tx_cnt + 4'h1;
    assign next_tx_idx = 4'h0 - next_tx_cnt;
    assign cur_tx_idx  = 4'h0 - tx_cnt;

    always_ff @(negedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
        begin
            tx_cnt        <= 4'h0;                              // RL13
            first_pending <= 1'b1;
            tx_bit        <= 1'b0;
        end
        else
        begin
            tx_cnt        <= next_tx_cnt;
            first_pending <= 1'b0;
            tx_bit        <= tx_word[next_tx_idx];              // RL2
        end
    end

    // msb straight from the reply register until the first falling edge,
    // since no serial edge exists yet to load a shifter
    assign dout_out      = first_pending ? tx_word[15] : tx_bit;  // RL3
    assign dout_oe_n_out = cs_n_in;                               // RL4

    // three-stage synchronisers for chip select and the word toggle
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            sync1 <= 2'h1;
            sync2 <= 2'h1;
            sync3 <= 2'h1;
        end
        else
        begin
            sync1 <= {rx_toggle, cs_n_in};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // a bit counts as changed once stages two and three agree
    assign next_filt = (sync3 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
    assign cs_idle   = filt[0];
    assign word_evt  = (filt[1] != seen_toggle);
    assign cs_fall   = cs_idle_q && !cs_idle;
    assign cs_rise   = !cs_idle_q && cs_idle;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            filt        <= 2'h1;
            cs_idle_q   <= 1'b1;
            seen_toggle <= 1'b0;
        end
        else
        begin
            filt        <= next_filt;
            cs_idle_q   <= cs_idle;
            seen_toggle <= filt[1];
        end
    end

    // reply word loads only while the synchronised chip select reads idle, so it can still change up to five clocks after chip select falls
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            tx_word <= `GYSPI_TX_RESET;
        else if (resp_valid_in && resp_ready_out)
            tx_word <= resp_data_in;                            // RL9
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            resp_ready_out <= 1'b0;
        else
            resp_ready_out <= cs_idle && !cs_fall;
    end

    // mode follows the sample period setting
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            low_power_out <= 1'b0;
        else
            low_power_out <= (sample_period_setting_in >= `GYSPI_LP_MIN);  // RL6
    end

    // decode each word received while none is held and offer it to the fifo
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            push_state <= GYSPI_ST_IDLE;
            push_cmd   <= '0;
        end
        else if (word_evt && push_state == GYSPI_ST_IDLE)
        begin
            push_state         <= GYSPI_ST_HOLD;                        // RL12
            push_cmd.write     <= rx_word[`GYSPI_RW_BIT];               // RL11
            push_cmd.reg_index <= rx_word[`GYSPI_ADDR_MSB:`GYSPI_REG_LSB];  // RL10
            push_cmd.byte_sel  <= rx_word[`GYSPI_ADDR_LSB];
            push_cmd.data      <= rx_word[`GYSPI_DATA_MSB:0];           // RL11
        end
        else if (push_state == GYSPI_ST_HOLD && fifo_in_ready)
            push_state <= GYSPI_ST_IDLE;
    end

    // a word arriving while the last one still waits on a full fifo is lost
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            overrun_out <= 1'b0;
        else
            overrun_out <= word_evt && push_state == GYSPI_ST_HOLD;
    end

    gyspi_fifo #(
        .WIDTH (`GYSPI_WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .srst_in       (srst_in),
        .in_valid_in   (push_state == GYSPI_ST_HOLD),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (push_cmd),
        .out_valid_out (cmd_valid_out),
        .out_ready_in  (cmd_ready_in),
        .out_data_out  (cmd_out)
    );

    // pacing limits depend on mode
    assign lp_mode    = low_power_out;
    assign period_min = lp_mode ? PERIOD_LP : PERIOD_NORM;
    assign stall_min  = lp_mode ? STALL_LP : STALL_NORM;

    // saturating counters since the last word and since deselect
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            period_cnt <= '0;
            stall_cnt  <= '0;
            seen_word  <= 1'b0;
        end
        else
        begin
            period_cnt <= word_evt ? CW'(1) : period_cnt + CW'(period_cnt != '1);
            stall_cnt  <= cs_rise ? CW'(1) : stall_cnt + CW'(stall_cnt != '1);
            seen_word  <= seen_word || word_evt;
        end
    end

    // checks master pacing; only a warning, the words are still taken
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            timing_error_out <= 1'b0;
        else
            timing_error_out <= seen_word
                && ((word_evt && period_cnt < period_min) || (cs_fall && stall_cnt < stall_min));  // RL8
    end

    // serial side checks
    sample_shift_a: assert property (@(posedge sclk_in) disable iff (cs_n_in)  // RL1
        rx_cnt != 4'h0 |-> rx_shift[0] == $past(din_in))
        else $error("input bit not captured on rising edge");

    bit_step_a: assert property (@(negedge sclk_in) disable iff (cs_n_in)  // RL2
        !first_pending |-> dout_out == tx_word[cur_tx_idx])
        else $error("output bit out of order");

    msb_early_a: assert property (@(posedge sclk_in) disable iff (cs_n_in)  // RL3
        rx_cnt == 4'h0 |-> dout_out == tx_word[15])
        else $error("msb not present at first rising edge");

    // system side checks
    float_out_a: assert property (@(posedge clk_in) disable iff (srst_in)  // RL4
        dout_oe_n_out == cs_n_in)
        else $error("output drive does not follow chip select");

    deselect_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)  // RL13
        cs_n_in |-> rx_cnt == 4'h0 && tx_cnt == 4'h0)
        else $error("bit counters alive while deselected");

    mode_select_a: assert property (@(posedge clk_in) disable iff (srst_in)  // RL6
        1'b1 |=> low_power_out == ($past(sample_period_setting_in) > 8'h07))
        else $error("mode flag wrong");

    word_handoff_a: assert property (@(posedge clk_in) disable iff (srst_in)  // RL12
        word_evt && push_state == GYSPI_ST_IDLE |=> push_state == GYSPI_ST_HOLD)
        else $error("received word not offered");

    addr_map_a: assert property (@(posedge clk_in) disable iff (srst_in)  // RL10
        word_evt && push_state == GYSPI_ST_IDLE
        |=> push_cmd.reg_index == $past(rx_word[14:9]) && push_cmd.byte_sel == $past(rx_word[8]))
        else $error("address not mapped to register");

    write_byte_a: assert property (@(posedge clk_in) disable iff (srst_in)  // RL11
        word_evt && push_state == GYSPI_ST_IDLE
        |=> push_cmd.write == $past(rx_word[15]) && push_cmd.data == $past(rx_word[7:0]))
        else $error("write byte decode wrong");

    reply_load_a: assert property (@(posedge clk_in) disable iff (srst_in)  // RL9
        resp_valid_in && resp_ready_out |=> tx_word == $past(resp_data_in))
        else $error("reply word not loaded");

    overrun_flag_a: assert property (@(posedge clk_in) disable iff (srst_in)
        word_evt && push_state == GYSPI_ST_HOLD |=> overrun_out)
        else $error("lost word not flagged");

    read_word_c: cover property (@(posedge clk_in) disable iff (srst_in)
        word_evt && !rx_word[15]);
    write_word_c: cover property (@(posedge clk_in) disable iff (srst_in)
        word_evt && rx_word[15]);
    low_power_word_c: cover property (@(posedge clk_in) disable iff (srst_in)
        word_evt && low_power_out);
    overrun_c: cover property (@(posedge clk_in) disable iff (srst_in)
        overrun_out);

endmodule : gyspi_port
`default_nettype wire

/* File: verification/gyspi_host_model.sv */
// spi master model facing the sensor serial port: mode 3, msb first, 16-bit words
// assumes the bench calls its tasks; the data wire level is resolved here from the port's enable
`timescale 1ns/10ps
`default_nettype none

module gyspi_host_model (
    output logic      sclk_out,  // serial clock, idle high
    output logic      cs_n_out,  // chip select, low active
    output logic      din_out,   // master to device data
    input  wire logic dout_in,   // device data
    input  wire logic oe_n_in    // device drive enable, low drives
);
    logic last_bit;  // last level the device drove
    logic miso;      // resolved wire level
    logic first_bit; // wire level just after chip select fell
    real  half_ns;   // half of the 125 ns link clock

    // a released wire shows the inverse of its last level, so a float never passes as data
    assign miso = oe_n_in ? ~last_bit : dout_in;
    always @(dout_in or oe_n_in)
        if (!oe_n_in)
            last_bit = dout_in;

    // chip select starts low and rises after 1 ns; the port's bit counters
    // clear only on that rising edge, so a rise at time zero could be missed
    initial
    begin
        sclk_out = 1'b1;
        cs_n_out = 1'b0;
        din_out  = 1'b0;
        last_bit = 1'b0;
        half_ns  = 62.5;
        #1;
        cs_n_out = 1'b1;
    end

    // one word under one chip select; clock stands still high outside it
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        cs_n_out = 1'b0;
        #60;
        first_bit = miso;
        for (int i = 15; i >= 0; i--)
        begin
            sclk_out = 1'b0;
            din_out  = tx[i];
            #(half_ns);
            sclk_out = 1'b1;
            rx[i]    = miso;
            #(half_ns);
        end
        cs_n_out = 1'b1;
        din_out  = ~din_out;
    endtask : frame

    // quiet time between words, chosen by the caller per mode
    task automatic pause(input real ns);
        #(ns);
    endtask : pause

    // clock pulses with chip select high, which the port must ignore
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++)
        begin
            sclk_out = 1'b0;
            din_out  = ~din_out;
            #(half_ns);
            sclk_out = 1'b1;
            #(half_ns);
        end
    endtask : idle_clocks
endmodule : gyspi_host_model
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the sensor serial port: read replies, writes, modes, pacing, buffer overrun
// assumes the port's package and constants header are compiled first
`include "gyspi_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

`define CHK(name, exp, got) \
    begin \
        comparisons++; \
        if ((exp) !== (got)) \
        begin \
            error_cnt++; \
            $display("[FAIL] %s expected %h seen %h", name, exp, got); \
        end \
    end

module testbench;
    import gyspi_pkg::*;
    typedef struct packed { logic [15:0] tx; logic [15:0] resp; } gyspi_tb_row_type;
    localparam int FD = 4; // small buffer keeps the fill test short
    localparam real GAP = 31000.0; // normal-mode gap keeping the word period above 32 us

    logic clk_in = 1'b0, srst_in = 1'b0, cmd_ready_in = 1'b0, resp_valid_in = 1'b0;
    logic [15:0] resp_data_in = 16'h0000;
    logic [7:0] setting = 8'h00;
    logic sclk, cs_n, din, dout, oe_n, low_power, cmd_valid, resp_ready, overrun, timing_err;
    gyspi_cmd_type cmd;
    int error_cnt = 0, comparisons = 0, te_cnt = 0, ov_cnt = 0, cyc = 0, te0, recv;
    logic [15:0] rx, prev;
    gyspi_tb_row_type rows [6];

    gyspi_port #(.FIFO_DEPTH(FD)) gyspi_port_i (.clk_in(clk_in), .srst_in(srst_in), .sclk_in(sclk),
        .cs_n_in(cs_n), .din_in(din), .dout_out(dout), .dout_oe_n_out(oe_n),
        .sample_period_setting_in(setting), .low_power_out(low_power), .cmd_valid_out(cmd_valid),
        .cmd_ready_in(cmd_ready_in), .cmd_out(cmd), .resp_valid_in(resp_valid_in),
        .resp_data_in(resp_data_in), .resp_ready_out(resp_ready), .overrun_out(overrun),
        .timing_error_out(timing_err));
    gyspi_host_model gyspi_host_model_i (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
        .dout_in(dout), .oe_n_in(oe_n));

    always #12.5 clk_in = ~clk_in;

    // pulse counters and the hang limit
    always @(posedge clk_in)
    begin
        cyc++;
        te_cnt += (timing_err === 1'b1);
        ov_cnt += (overrun === 1'b1);
        if (cyc == 60000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    // consumer side: wait bounded for a word, compare, take it
    task automatic take_cmd(input logic [15:0] exp);
        for (int n = 0; n < 40 && cmd_valid !== 1'b1; n++)
            tick(1);
        `CHK("cmd_valid", 1'b1, cmd_valid)
        `CHK("cmd_out", exp, cmd)
        `CHK("reg_index", exp[14:9], cmd.reg_index)
        cmd_ready_in = 1'b1;
        tick(1);
        cmd_ready_in = 1'b0;
    endtask : take_cmd

    // register side: reply word loaded while chip select is idle
    task automatic load_resp(input logic [15:0] d);
        for (int n = 0; n < 40 && resp_ready !== 1'b1; n++)
            tick(1);
        resp_valid_in = 1'b1;
        resp_data_in  = d;
        tick(1);
        resp_valid_in = 1'b0;
    endtask : load_resp

    // one word with its trailing gap; the released output enable and, when take is set, the received command are checked, the reply shifted out is not
    task automatic word(input logic [15:0] tx, input real gap, input bit take);
        gyspi_host_model_i.frame(tx, rx);
        `CHK("dout_oe_n", 1'b1, oe_n)
        fork
            gyspi_host_model_i.pause(gap);
            if (take)
                take_cmd(tx);
        join
    endtask : word

    task automatic give_verdict;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    initial
    begin
        rows = '{'{16'h0800, 16'hA5C3}, '{16'h0900, 16'h5A3C}, '{16'hBE01, 16'hFFFF},
                 '{16'hBF12, 16'h0001}, '{16'h7F00, 16'h8000}, '{16'h8000, 16'h7FFE}};
        // reset rises after time zero so the word toggle's asynchronous clear sees an edge
        #1;
        srst_in = 1'b1;
        tick(2);
        srst_in = 1'b0;
        tick(1);
        `CHK("low_power", 1'b0, low_power)
        `CHK("cmd_valid", 1'b0, cmd_valid)
        `CHK("dout_oe_n", 1'b1, oe_n)
        tick(5);
        `CHK("resp_ready", 1'b1, resp_ready)
        // reads and writes; the first word returns the reset value, each later one the reply loaded after the word before it
        prev = `GYSPI_TX_RESET;
        for (int r = 0; r < 6; r++)
        begin
            gyspi_host_model_i.frame(rows[r].tx, rx);
            `CHK("first_bit", prev[15], gyspi_host_model_i.first_bit)
            `CHK("reply", prev, rx)
            `CHK("dout_oe_n", 1'b1, oe_n)
            fork
                gyspi_host_model_i.pause(GAP);
                begin
                    take_cmd(rows[r].tx);
                    load_resp(rows[r].resp);
                end
            join
            prev = rows[r].resp;
        end
        `CHK("no_pacing_error", 0, te_cnt)
        // mode threshold at both sides of the boundary
        foreach (rows[k])
        begin
            setting = (k == 0) ? 8'h00 : (k == 1) ? 8'h07 : (k == 2) ? 8'h08 : 8'hFF;
            tick(2);
            `CHK("low_power", (setting >= 8'h08), low_power)
        end
        // 37 us word period: too short in low-power mode, fine in normal mode
        gyspi_host_model_i.pause(45000.0);
        te0 = te_cnt;
        word(16'h0400, 35000.0, 1);
        word(16'h0500, 45000.0, 1);
        `CHK("lp_period", 1'b1, te_cnt == te0 + 1)
        setting = 8'h07;
        te0 = te_cnt;
        word(16'h0400, 35000.0, 1);
        word(16'h0500, 5000.0, 1);
        `CHK("norm_period", 1'b1, te_cnt == te0)
        word(16'h0600, GAP, 1);
        `CHK("short_stall", 1'b1, te_cnt > te0)
        // clock activity while deselected must not shift anything in
        gyspi_host_model_i.idle_clocks(5);
        gyspi_host_model_i.pause(GAP);
        word(16'hC3A5, GAP, 1);
        `CHK("no_extra_word", 1'b0, cmd_valid)
        // consumer stalls until words are lost, then drains in order
        te0 = ov_cnt;
        for (int k = 0; k < FD + 4; k++)
            word(16'h8000 | 16'(k), GAP, 0);
        recv = 0;
        for (int k = 0; k < FD + 4 && cmd_valid === 1'b1; k++)
        begin
            take_cmd(16'h8000 | 16'(k));
            recv++;
        end
        `CHK("drained", 1'b0, cmd_valid)
        `CHK("overrun_sum", 1'b1, recv + ov_cnt - te0 == FD + 4)
        `CHK("buffer_held", 1'b1, recv >= FD + 1)
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
